// file: verilog/clock_route_pkg.sv
// Shared constants and types for the clock source routing configuration
package clock_route_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int unsigned APB_AW        = 12;
    localparam int unsigned NREG          = 3;

    localparam logic [9:0] IDX_PLL_CTRL   = 10'h010;
    localparam logic [9:0] IDX_VCO_DIV    = 10'h1E0;
    localparam logic [9:0] IDX_ROUTE_SEL  = 10'h1E1;
    localparam logic [9:0] IDX_REG_UPDATE = 10'h232;
    localparam logic [9:0] IDX_STATUS     = 10'h233;

    localparam logic [APB_AW-1:0] ADDR_PLL_CTRL   = {IDX_PLL_CTRL, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_VCO_DIV    = {IDX_VCO_DIV, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_ROUTE_SEL  = {IDX_ROUTE_SEL, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_REG_UPDATE = {IDX_REG_UPDATE, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_STATUS     = {IDX_STATUS, 2'h0};

    // ------------------------------------------------------------------
    // Field layout and codes
    // ------------------------------------------------------------------
    localparam int unsigned PFD_POL_BIT    = 7;
    localparam int unsigned DIV_BYPASS_BIT = 0;
    localparam int unsigned SRC_VCO_BIT    = 1;

    localparam logic [1:0] PLL_MODE_NORMAL  = 2'h0;
    localparam logic [1:0] PLL_MODE_ASYNCPD = 2'h1;
    localparam logic [2:0] DIV_CODE_MAX     = 3'h4;
    localparam logic [2:0] DIV_CODE_OFFSET  = 3'h2;
    localparam logic [2:0] DIV_RATIO_BYPASS = 3'h1;
    localparam logic [7:0] UPDATE_GO        = 8'h01;

    // Slot order: 0 pll control, 1 vco divider, 2 routing select
    localparam logic [NREG-1:0][7:0] CFG_RESET = {8'h00, 8'h02, 8'h01};
    localparam logic [NREG-1:0][7:0] CFG_MASK  = {8'h03, 8'h07, 8'hFF};

    // ------------------------------------------------------------------
    // Active routing settings
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       pfdNegative;
        logic [1:0] pllMode;
        logic [2:0] vcoDivCode;
        logic       divBypass;
        logic       srcVco;
    } clk_route_t;

    localparam clk_route_t ROUTE_RESET = '{
        pfdNegative: 1'b0,
        pllMode:     2'h1,
        vcoDivCode:  3'h2,
        divBypass:   1'b0,
        srcVco:      1'b0
    };
    localparam logic [2:0] DIST_DIV_RESET = 3'h4;

endpackage : clock_route_pkg

// file: verilog/staged_cfg_reg.sv
// Staging register with a shadow copy that loads on commit
`timescale 1ns/1ps
`default_nettype none

module staged_cfg_reg #(
    parameter int unsigned  W    = 8,
    parameter logic [W-1:0] RST  = '0,
    parameter logic [W-1:0] MASK = '1
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Software side
    input  wire logic         wrEn,
    input  wire logic [W-1:0] wrData,
    input  wire logic         commit,
    // Values
    output logic      [W-1:0] stage,
    output logic      [W-1:0] active
);

    logic [W-1:0] stage_ff;
    logic [W-1:0] active_ff;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage_ff <= RST;
        end
        else if (wrEn)
        begin
            stage_ff <= wrData & MASK;
        end
    end

    // Write and commit in one cycle: commit takes the older staged value
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            active_ff <= RST;
        end
        else if (commit)
        begin
            active_ff <= stage_ff;
        end
    end

    assign stage  = stage_ff;
    assign active = active_ff;

endmodule // staged_cfg_reg

`default_nettype wire

// file: verilog/clock_source_routing_config.sv
// APB-programmed routing of the distribution clock path with staged update
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - After reset the PLL power mode is asynchronous power-down (PLL off).
// - Power-mode code 00 switches the PLL on.
// - VCO divider ratio code resets to 010, divide by four.
// - Divider-path bit clear routes the clock input through the VCO divider.
// - Source bit clear selects the external clock input; reset default.
// - On the divider path the ratio is never below two.
// - Written values take effect only after writing 0x01 to update.
// - PFD polarity bit clear is positive, set is negative.
// - PLL on with external source keeps internal VCO off, feeds prescaler.
// - Divider ratio field accepts only ratios two through six.
// - Divider-path bit set bypasses the VCO divider.
// - Source bit set selects the internal VCO as source.
module clock_source_routing_config
    import clock_route_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Active routing
    output clk_route_t             route,
    output logic                   pllOn,
    output logic                   vcoPowerOn,
    output logic                   prescalerFromExt,
    output logic                   distFromVco,
    output logic      [2:0]        distDivide
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [31:0]           prdata_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;
    logic                  updPend_ff;
    logic [NREG-1:0][7:0]  stageVec;
    logic [NREG-1:0][7:0]  activeVec;
    logic [NREG-1:0]       regWr;

    wire setupPh  = psel & ~penable;
    wire accessPh = psel & penable & pready_ff;
    wire wrDone   = accessPh & pwrite;

    wire hitPll    = (paddr == ADDR_PLL_CTRL);
    wire hitDiv    = (paddr == ADDR_VCO_DIV);
    wire hitRoute  = (paddr == ADDR_ROUTE_SEL);
    wire hitUpd    = (paddr == ADDR_REG_UPDATE);
    wire hitStatus = (paddr == ADDR_STATUS);
    wire hitAny    = hitPll | hitDiv | hitRoute | hitUpd | hitStatus;

    // Ratio codes above the last legal one are refused whole
    wire ratioBad  = (pwdata[2:0] > DIV_CODE_MAX);

    wire errNow = ~hitAny
                | (pwrite & hitDiv & ratioBad)
                | (pwrite & hitStatus);

    assign regWr[0] = wrDone & hitPll;
    assign regWr[1] = wrDone & hitDiv & ~ratioBad;
    assign regWr[2] = wrDone & hitRoute;

    wire updWr = wrDone & hitUpd & (pwdata[7:0] == UPDATE_GO);

    // ------------------------------------------------------------------
    // Staged configuration registers
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++)
        begin : g_cfg
            staged_cfg_reg #(
                .W    (8),
                .RST  (CFG_RESET[gi]),
                .MASK (CFG_MASK[gi])
            ) u_reg (
                .clk    (clk),
                .rst_b  (rst_b),
                .wrEn   (regWr[gi]),
                .wrData (pwdata[7:0]),
                .commit (updPend_ff),
                .stage  (stageVec[gi]),
                .active (activeVec[gi])
            );
        end
    endgenerate

    // Update pulse lives one cycle, so the bit reads back as clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            updPend_ff <= 1'b0;
        end
        else
        begin
            updPend_ff <= updWr;
        end
    end

    // ------------------------------------------------------------------
    // Routing derived from the active copy
    // ------------------------------------------------------------------
    clk_route_t route_ff;
    logic       pllOn_ff;
    logic       vcoPowerOn_ff;
    logic       prescalerFromExt_ff;
    logic       distFromVco_ff;
    logic [2:0] distDivide_ff;

    clk_route_t nxt_route;
    assign nxt_route.pfdNegative = activeVec[0][PFD_POL_BIT];
    assign nxt_route.pllMode     = activeVec[0][1:0];
    assign nxt_route.vcoDivCode  = activeVec[1][2:0];
    assign nxt_route.divBypass   = activeVec[2][DIV_BYPASS_BIT];
    assign nxt_route.srcVco      = activeVec[2][SRC_VCO_BIT];

    wire       nxt_pllOn = (nxt_route.pllMode == PLL_MODE_NORMAL);
    // Internal VCO only runs when the loop actually closes around it
    wire       nxt_vcoPowerOn = nxt_pllOn & nxt_route.srcVco;
    wire       nxt_prescalerFromExt = nxt_pllOn & ~nxt_route.srcVco;
    wire       nxt_distFromVco = nxt_route.srcVco;
    // Code 0 is divide by two: no divide-by-one on this path
    wire [2:0] divRatio = 3'(nxt_route.vcoDivCode + DIV_CODE_OFFSET);
    wire [2:0] nxt_distDivide = nxt_route.divBypass
                              ? DIV_RATIO_BYPASS
                              : divRatio;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            route_ff            <= ROUTE_RESET;
            pllOn_ff            <= 1'b0;
            vcoPowerOn_ff       <= 1'b0;
            prescalerFromExt_ff <= 1'b0;
            distFromVco_ff      <= 1'b0;
            distDivide_ff       <= DIST_DIV_RESET;
        end
        else
        begin
            route_ff            <= nxt_route;
            pllOn_ff            <= nxt_pllOn;
            vcoPowerOn_ff       <= nxt_vcoPowerOn;
            prescalerFromExt_ff <= nxt_prescalerFromExt;
            distFromVco_ff      <= nxt_distFromVco;
            distDivide_ff       <= nxt_distDivide;
        end
    end

    // ------------------------------------------------------------------
    // Read data and APB answer
    // ------------------------------------------------------------------
    // Config reads show the staged value; status shows what is in force
    wire [7:0] statusByte = {route_ff.pfdNegative, vcoPowerOn_ff,
                             distFromVco_ff, prescalerFromExt_ff,
                             pllOn_ff, distDivide_ff};

    wire [7:0] rdByte = ({8{hitPll}}    & stageVec[0])
                      | ({8{hitDiv}}    & stageVec[1])
                      | ({8{hitRoute}}  & stageVec[2])
                      | ({8{hitUpd}}    & {7'h00, updPend_ff})
                      | ({8{hitStatus}} & statusByte);

    wire        nxt_pready  = setupPh;
    wire [31:0] nxt_prdata  = (setupPh & ~pwrite) ? {24'h000000, rdByte}
                                                  : 32'h00000000;
    wire        nxt_pslverr = setupPh & errNow;

    // Answer is ready on the first access cycle: zero wait states
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff  <= nxt_pready;
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign route            = route_ff;
    assign pllOn            = pllOn_ff;
    assign vcoPowerOn       = vcoPowerOn_ff;
    assign prescalerFromExt = prescalerFromExt_ff;
    assign distFromVco      = distFromVco_ff;
    assign distDivide       = distDivide_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic committed_ff;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            committed_ff <= 1'b0;
        end
        else if (updPend_ff)
        begin
            committed_ff <= 1'b1;
        end
    end

    property p_resetPllOff;
        !committed_ff && !updPend_ff |=>
            route.pllMode == PLL_MODE_ASYNCPD && !pllOn;
    endproperty
    a_resetPllOff: assert property (p_resetPllOff)
        else $error("PLL not powered down before first update");

    property p_resetDefaults;
        !committed_ff && !updPend_ff |=>
            route.vcoDivCode == 3'h2 && distDivide == 3'h4
            && !route.divBypass && !route.srcVco;
    endproperty
    a_resetDefaults: assert property (p_resetDefaults)
        else $error("Routing defaults lost before first update");

    property p_normalMode;
        route.pllMode == PLL_MODE_NORMAL |-> pllOn;
    endproperty
    a_normalMode: assert property (p_normalMode)
        else $error("Normal mode code did not switch PLL on");

    property p_holdUntilUpdate;
        !updPend_ff |=> $stable(activeVec) ##1 $stable(route);
    endproperty
    a_holdUntilUpdate: assert property (p_holdUntilUpdate)
        else $error("Active settings moved without an update");

    property p_commitCopies;
        updPend_ff |=> activeVec == $past(stageVec);
    endproperty
    a_commitCopies: assert property (p_commitCopies)
        else $error("Update did not copy staged values");

    property p_selfClear;
        updWr |=> updPend_ff ##1 !updPend_ff;
    endproperty
    a_selfClear: assert property (p_selfClear)
        else $error("Update bit did not clear itself");

    property p_polarity;
        1'b1 |=> route.pfdNegative == $past(activeVec[0][PFD_POL_BIT]);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("PFD polarity does not follow active bit");

    property p_extVco;
        pllOn && !route.srcVco |-> !vcoPowerOn && prescalerFromExt;
    endproperty
    a_extVco: assert property (p_extVco)
        else $error("Internal VCO powered with external source");

    property p_divPath;
        !route.divBypass |-> distDivide >= 3'h2 && distDivide <= 3'h6;
    endproperty
    a_divPath: assert property (p_divPath)
        else $error("Divider path ratio out of two to six");

    property p_ratioLegal;
        route.vcoDivCode <= DIV_CODE_MAX;
    endproperty
    a_ratioLegal: assert property (p_ratioLegal)
        else $error("Illegal divider ratio code in force");

    property p_bypass;
        route.divBypass |-> distDivide == 3'h1;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("Bypass did not skip the VCO divider");

    property p_source;
        distFromVco == route.srcVco;
    endproperty
    a_source: assert property (p_source)
        else $error("Source selection not followed");

    property p_ratioRefused;
        wrDone && hitDiv && ratioBad |=> stageVec[1] == $past(stageVec[1]);
    endproperty
    a_ratioRefused: assert property (p_ratioRefused)
        else $error("Refused ratio code reached staging");

    property p_ratioErr;
        psel && !penable && pwrite && hitDiv && ratioBad |=> pready && pslverr;
    endproperty
    a_ratioErr: assert property (p_ratioErr)
        else $error("Refused ratio code answered without error");

    property p_updIgnored;
        wrDone && hitUpd && pwdata[7:0] != UPDATE_GO |=> !updPend_ff;
    endproperty
    a_updIgnored: assert property (p_updIgnored)
        else $error("Update started by a value other than one");

    property p_srcExt;
        !route.srcVco |-> !distFromVco && !vcoPowerOn;
    endproperty
    a_srcExt: assert property (p_srcExt)
        else $error("External source not selected while bit clear");

    property p_apbAnswer;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apbAnswer: assert property (p_apbAnswer)
        else $error("APB answer not one cycle after setup");

    c_update: cover property (updWr ##2 activeVec != $past(activeVec));
    c_pllOn: cover property (pllOn && !route.srcVco);
    c_vcoSource: cover property (vcoPowerOn && !route.divBypass);
    c_badRatio: cover property (pslverr && pready);

endmodule // clock_source_routing_config

`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the clock source routing configuration
`timescale 1ns/1ps
`default_nettype none

module tb import clock_route_pkg::*;;

    // ------------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------------
    logic              clk;
    logic              rst_b;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    clk_route_t        route;
    logic              pllOn;
    logic              vcoPowerOn;
    logic              prescalerFromExt;
    logic              distFromVco;
    logic [2:0]        distDivide;
    int                mismatches;
    int                checks;
    logic [15:0]       lfsrState;
    logic [7:0]        stg [3];
    logic [7:0]        act [3];
    logic [11:0]       addrs [6];

    always #12.5 clk = ~clk;

    clock_source_routing_config u_dut (
        .clk              (clk),
        .rst_b            (rst_b),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .route            (route),
        .pllOn            (pllOn),
        .vcoPowerOn       (vcoPowerOn),
        .prescalerFromExt (prescalerFromExt),
        .distFromVco      (distFromVco),
        .distDivide       (distDivide)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic int slot(input logic [11:0] a);
        case (a)
            ADDR_PLL_CTRL:   slot = 0;
            ADDR_VCO_DIV:    slot = 1;
            ADDR_ROUTE_SEL:  slot = 2;
            ADDR_REG_UPDATE: slot = 3;
            ADDR_STATUS:     slot = 4;
            default:         slot = 5;
        endcase
    endfunction

    function automatic logic [7:0] msk(input int k);
        msk = (k == 0) ? 8'hFF : (k == 1) ? 8'h07 : 8'h03;
    endfunction

    function automatic logic [7:0] exp_stat();
        logic       on;
        logic       src;
        logic [2:0] dv;
        on  = (act[0][1:0] == 2'h0);
        src = act[2][1];
        dv  = act[2][0] ? 3'h1 : act[1][2:0] + 3'h2;
        exp_stat = {act[0][7], on & src, src, on & ~src, on, dv};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        checks++;
        if (seen !== expv)
        begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_out;
        logic [7:0] s;
        s = exp_stat();
        chk({24'h0, route}, {24'h0, act[0][7], act[0][1:0], act[1][2:0],
            act[2][0], act[2][1]});
        chk({31'h0, pllOn}, {31'h0, s[3]});
        chk({31'h0, vcoPowerOn}, {31'h0, s[6]});
        chk({31'h0, prescalerFromExt}, {31'h0, s[4]});
        chk({31'h0, distFromVco}, {31'h0, s[5]});
        chk({29'h0, distDivide}, {29'h0, s[2:0]});
    endtask

    // ------------------------------------------------------------------
    // Bus master with model compare
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int          n;
        int          k;
        logic [31:0] rd;
        logic        er;
        logic        erx;
        logic [31:0] rdx;
        k = slot(a);
        lfsrState = lfsr_next(lfsrState);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {lfsrState, lfsrState[7:0], d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            mismatches++;
            tally_and_finish;
        end
        erx = w ? (k >= 4 || (k == 1 && d[2:0] > 3'h4)) : (k == 5);
        chk({31'h0, er}, {31'h0, erx});
        rdx = (k < 3) ? {24'h0, stg[k]} : (k == 4) ? {24'h0, exp_stat()}
            : 32'h0;
        if (!w)
            chk(rd, rdx);
        if (w && !erx && k < 3)
            stg[k] = d & msk(k);
        if (w && k == 3 && d == 8'h01)
        begin
            act = stg;
            // Outputs follow two edges later; a status read must wait
            repeat (2) @(posedge clk);
        end
    endtask

    task automatic commit;
        apb(1'b1, ADDR_REG_UPDATE, UPDATE_GO);
        repeat (3) @(posedge clk);
        chk_out;
    endtask

    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        stg[0] = 8'h01;
        stg[1] = 8'h02;
        stg[2] = 8'h00;
        act = stg;
        @(posedge clk);
        chk_out;
        for (int i = 0; i < 6; i++)
            apb(1'b0, addrs[i], 8'h00);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        mismatches = 0;
        checks = 0;
        lfsrState = 16'hCC2F;
        addrs = '{ADDR_PLL_CTRL, ADDR_VCO_DIV, ADDR_ROUTE_SEL,
                  ADDR_REG_UPDATE, ADDR_STATUS, 12'hFFC};
        do_reset;
        // Staged values stay hidden; wrong update bytes do nothing
        apb(1'b1, ADDR_PLL_CTRL, 8'h80);
        apb(1'b1, ADDR_ROUTE_SEL, 8'h03);
        apb(1'b1, ADDR_REG_UPDATE, 8'h03);
        apb(1'b1, ADDR_REG_UPDATE, 8'h00);
        repeat (3) @(posedge clk);
        chk_out;
        commit;
        apb(1'b1, ADDR_ROUTE_SEL, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, ADDR_VCO_DIV, 8'(c));
            commit;
            apb(1'b0, ADDR_STATUS, 8'h00);
        end
        // Every power mode against every routing choice
        for (int m = 0; m < 4; m++)
            for (int r = 0; r < 4; r++)
            begin
                apb(1'b1, ADDR_PLL_CTRL, {r[0], 5'h0, 2'(m)});
                apb(1'b1, ADDR_ROUTE_SEL, 8'(r));
                commit;
                apb(1'b0, ADDR_STATUS, 8'h00);
            end
        for (int i = 0; i < 24; i++)
        begin
            apb(1'b1, addrs[lfsrState % 6], lfsrState[15:8]);
            apb(1'b0, addrs[i % 6], 8'h00);
            if (i % 4 == 3)
                commit;
        end
        // Reset in mid-run brings back the defaults
        apb(1'b1, ADDR_VCO_DIV, 8'h04);
        commit;
        do_reset;
        tally_and_finish;
    end

endmodule // tb

`default_nettype wire
